// ===== common/sia_params.svh
/*
  Offsets, field positions, reset values and timing counts of the status and
  interrupt aggregator. Assumes byte addresses as seen on the register port.
*/
`ifndef SIA_PARAMS_SVH
`define SIA_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SIA_ADDR_W          8
`define SIA_OFF_MSTAT       8'h20
`define SIA_OFF_MMASK       8'h24
`define SIA_OFF_DSTAT       8'h28
`define SIA_OFF_DMASK       8'h2c
`define SIA_OFF_LSTAT       8'h30
`define SIA_OFF_LMASK       8'h34

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define SIA_REG_W           16
`define SIA_RST_VAL         16'h0000
`define SIA_BIT_RX_ALIGN    0
`define SIA_BIT_TX_ALIGN    1
`define SIA_BIT_TESTER      2
`define SIA_BIT_SYS_ERR     3
`define SIA_BIT_PAR_ERR     4
`define SIA_BIT_LB_TIMEOUT  14
`define SIA_BIT_LB_IRQ      15
`define SIA_MSTAT_USED      16'hc01f
`define SIA_DSTAT_USED      16'hfffc
`define SIA_BIT_DMA_CRC     2
`define SIA_BIT_DMA_OVFL    5

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SIA_LB_TIMEOUT_LOCAL_BUS_CLOCK 9
`define SIA_LOCAL_BUS_CLOCK_DIV        1

`endif

// ===== common/sia_pkg.sv
/*
  Types shared by the status and interrupt aggregator files.
  Assumes sia_params.svh supplies the widths.
*/
`include "sia_params.svh"

package sia_pkg;
  typedef logic [`SIA_REG_W-1:0] sia_word_type;

  typedef enum logic [1:0] {
    SIA_LB_IDLE = 2'b01,
    SIA_LB_WAIT = 2'b10
  } sia_lb_state_type;
endpackage

// ===== common/sia_reg_if.sv
/*
  Carrier between the top and one clear-on-read status/mask register pair.
  Assumes a single clock domain owned by the top.
*/
`timescale 1ns/10ps

interface sia_reg_if #(parameter int W = 16);
  logic [W-1:0] set;
  logic         rd_clr;
  logic         mask_wr;
  logic [W-1:0] wdata;
  logic [W-1:0] status;
  logic [W-1:0] mask;
  logic         pending;

  modport ctl (output set, output rd_clr, output mask_wr, output wdata,
               input status, input mask, input pending);
  modport regs (input set, input rd_clr, input mask_wr, input wdata,
                output status, output mask, output pending);
endinterface

// ===== verilog/sia_status_reg.sv
/*
  One sticky status register with its mask register.
  Assumes set, read-clear and mask write come from logic on core_clk.
*/
`timescale 1ns/10ps
`include "sia_params.svh"

module sia_status_reg #(
  parameter int          W    = 16,
  parameter logic [15:0] USED = 16'hffff
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  sia_reg_if.regs   rif
);
  logic [W-1:0] status_q;
  logic [W-1:0] status_d;
  logic [W-1:0] mask_q;
  logic [W-1:0] used_bits;

  assign used_bits = USED[W-1:0];
  // set wins over the read clear so no event is lost
  assign status_d  = ((status_q & ~{W{rif.rd_clr}}) | rif.set) & used_bits;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= W'(`SIA_RST_VAL);
      mask_q   <= W'(`SIA_RST_VAL);
    end else begin
      status_q <= status_d;
      if (rif.mask_wr) begin
        mask_q <= rif.wdata & used_bits;
      end
    end
  end

  assign rif.status  = status_q;
  assign rif.mask    = mask_q;
  assign rif.pending = |(status_q & mask_q);
endmodule

// ===== verilog/sia_top.sv
/*
  Status and interrupt aggregator: three clear-on-read status registers with
  masks, the local access timeout, and the two interrupt pins.
  Assumes event inputs are one-cycle pulses from logic on core_clk, except the
  local bus pins, which are asynchronous and synchronised here.
*/
// Summary of operation
// - status bits set on events; a read clears them until the next event
// - any status bit raises host irq; also local irq in configuration mode
// - each status register has a mask; 0 blocks, 1 passes the interrupt
// - status bits keep setting even while their mask blocks the interrupt
// - bit 0 receive alignment change summary, bit 1 transmit summary
// - per-port enables gate each port's alignment change into the summaries
// - bit 2 sets on tester sync change, bit error or counter overflow
// - tester events are individually maskable; host reads tester status
// - bit 3 mirrors bus system error, also passed to configuration status
// - bit 4 mirrors bus parity error, direct or reported by a target
// - bridge mode: bit 14 sets when ready is missing for nine local clocks
// - bridge mode: bit 15 sets on local irq input; raises host irq only
// - loopback status holds one bit per port, set on timeout or pattern
// - after detector timeout the port bit stays set until the first read after detector reset
// - dma status reports queue accesses, queue errors, fifo and receive errors
// - bus events, loopback events and dma events on bits 2 to 15 are always recorded, never suppressed
// - dma status at 0x28: overflow in bit 5, crc error in bit 2
`timescale 1ns/10ps
`include "sia_params.svh"

module sia_top #(
  parameter int PORTS   = 16,
  parameter int LOCAL_BUS_CLOCK_DIV = `SIA_LOCAL_BUS_CLOCK_DIV
) (
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  // register port
  input  wire logic [`SIA_ADDR_W-1:0] reg_addr,
  input  wire logic                   reg_rd,
  input  wire logic                   reg_wr,
  input  wire logic [`SIA_REG_W-1:0]  reg_wdata,
  output logic      [`SIA_REG_W-1:0]  reg_rdata,
  // port framers
  input  wire logic [PORTS-1:0]       port_rx_align_change,
  input  wire logic [PORTS-1:0]       rx_align_irq_enable,
  input  wire logic [PORTS-1:0]       port_tx_align_change,
  input  wire logic [PORTS-1:0]       tx_align_irq_enable,
  // tester receiver
  input  wire logic                   tester_sync_change,
  input  wire logic                   tester_bit_error,
  input  wire logic                   tester_count_overflow,
  input  wire logic                   tester_sync_ie,
  input  wire logic                   tester_bit_error_ie,
  input  wire logic                   tester_overflow_ie,
  // host bus errors
  input  wire logic                   bus_system_error,
  input  wire logic                   bus_parity_error,
  output logic                        bus_system_error_flag,
  output logic                        bus_parity_error_flag,
  // local bus
  input  wire logic                   local_cfg_mode,
  input  wire logic                   local_access_start,
  input  wire logic                   local_ready_n,
  input  wire logic                   local_irq_n_in,
  output logic                        local_irq_n_out,
  output logic                        local_irq_n_oe,
  // loopback detectors and dma
  input  wire logic [PORTS-1:0]       port_loopback_event,
  input  wire logic [PORTS-1:0]       loopback_search_timeout,
  input  wire logic [`SIA_REG_W-1:0]  dma_event,
  // interrupt pin
  output logic                        host_irq_n
);

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function automatic logic sia_hit(input logic [`SIA_ADDR_W-1:0] a,
                                   input logic [`SIA_ADDR_W-1:0] off);
    sia_hit = (a == off);
  endfunction

  // status offsets have no write strobe, so writes to them are dropped
  wire hit_mstat = sia_hit(reg_addr, `SIA_OFF_MSTAT);
  wire hit_mmask = sia_hit(reg_addr, `SIA_OFF_MMASK);
  wire hit_dstat = sia_hit(reg_addr, `SIA_OFF_DSTAT);
  wire hit_dmask = sia_hit(reg_addr, `SIA_OFF_DMASK);
  wire hit_lstat = sia_hit(reg_addr, `SIA_OFF_LSTAT);
  wire hit_lmask = sia_hit(reg_addr, `SIA_OFF_LMASK);

  sia_reg_if #(.W(`SIA_REG_W)) m_if ();
  sia_reg_if #(.W(`SIA_REG_W)) d_if ();
  sia_reg_if #(.W(PORTS))      l_if ();

  // ----------------------------------------------------------------------
  // local bus pin synchronisers
  // ----------------------------------------------------------------------
  logic ready_meta_q;
  logic ready_sync_q;
  logic lirq_meta_q;
  logic lirq_sync_q;
  logic lirq_prev_q;

  // pins idle high, so reset to the inactive level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_meta_q <= 1'b1;
      ready_sync_q <= 1'b1;
      lirq_meta_q  <= 1'b1;
      lirq_sync_q  <= 1'b1;
      lirq_prev_q  <= 1'b1;
    end else begin
      ready_meta_q <= local_ready_n;
      ready_sync_q <= ready_meta_q;
      lirq_meta_q  <= local_irq_n_in;
      lirq_sync_q  <= lirq_meta_q;
      lirq_prev_q  <= lirq_sync_q;
    end
  end

  // only in bridge mode is the local irq pin an input
  // the event is the asserting edge, so a held-low pin sets the bit once
  wire lirq_fall = lirq_prev_q & ~lirq_sync_q & ~local_cfg_mode;

  // ----------------------------------------------------------------------
  // local clock enable and access timeout
  // ----------------------------------------------------------------------
  // a larger LOCAL_BUS_CLOCK_DIV stretches the window; the nine-period count stays fixed
  localparam int DIV_W = (LOCAL_BUS_CLOCK_DIV > 1) ? $clog2(LOCAL_BUS_CLOCK_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LOCAL_BUS_CLOCK_DIV - 1);
  localparam logic [3:0] LB_LIMIT = 4'(`SIA_LB_TIMEOUT_LOCAL_BUS_CLOCK);

  logic [DIV_W-1:0]          div_q;
  logic [3:0]                lb_cnt_q;
  sia_pkg::sia_lb_state_type lb_state_q;
  logic                      lb_timeout_q;

  wire local_bus_clock_en   = (div_q == DIV_LAST);
  wire ready_hit = ~ready_sync_q;
  // the timeout only counts in bridge mode, where the local bus is a master
  wire lb_expire = (lb_state_q == sia_pkg::SIA_LB_WAIT) & local_bus_clock_en & ~ready_hit
                   & (lb_cnt_q == LB_LIMIT - 4'h1);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
    end else begin
      div_q <= local_bus_clock_en ? '0 : div_q + DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lb_state_q   <= sia_pkg::SIA_LB_IDLE;
      lb_cnt_q     <= 4'h0;
      lb_timeout_q <= 1'b0;
    end else begin
      lb_timeout_q <= lb_expire;
      unique case (lb_state_q)
        sia_pkg::SIA_LB_IDLE: begin
          lb_cnt_q <= 4'h0;
          if (local_access_start && !local_cfg_mode) begin
            lb_state_q <= sia_pkg::SIA_LB_WAIT;
          end
        end
        sia_pkg::SIA_LB_WAIT: begin
          // starts seen here are ignored, one access at a time
          if (ready_hit || lb_expire || local_cfg_mode) begin
            lb_state_q <= sia_pkg::SIA_LB_IDLE;
          end else if (local_bus_clock_en) begin
            lb_cnt_q <= lb_cnt_q + 4'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // master event sources
  // ----------------------------------------------------------------------
  wire rx_sum = |(port_rx_align_change & rx_align_irq_enable);
  wire tx_sum = |(port_tx_align_change & tx_align_irq_enable);
  wire tester_sum = (tester_sync_change & tester_sync_ie)
                  | (tester_bit_error & tester_bit_error_ie)
                  | (tester_count_overflow & tester_overflow_ie);

  logic [`SIA_REG_W-1:0] mstat_set;

  always_comb begin
    mstat_set                      = `SIA_RST_VAL;
    mstat_set[`SIA_BIT_RX_ALIGN]   = rx_sum;
    mstat_set[`SIA_BIT_TX_ALIGN]   = tx_sum;
    mstat_set[`SIA_BIT_TESTER]     = tester_sum;
    mstat_set[`SIA_BIT_SYS_ERR]    = bus_system_error;
    mstat_set[`SIA_BIT_PAR_ERR]    = bus_parity_error;
    mstat_set[`SIA_BIT_LB_TIMEOUT] = lb_timeout_q;
    mstat_set[`SIA_BIT_LB_IRQ]     = lirq_fall;
  end

  // ----------------------------------------------------------------------
  // loopback detector sources
  // ----------------------------------------------------------------------
  logic [PORTS-1:0] lstat_set;

  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      // a standing timeout re-sets the bit after every read
      assign lstat_set[p] = port_loopback_event[p]
                          | loopback_search_timeout[p];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // register instances
  // ----------------------------------------------------------------------
  assign m_if.set     = mstat_set;
  assign m_if.rd_clr  = reg_rd & hit_mstat;
  assign m_if.mask_wr = reg_wr & hit_mmask;
  assign m_if.wdata   = reg_wdata;

  assign d_if.set     = dma_event;
  assign d_if.rd_clr  = reg_rd & hit_dstat;
  assign d_if.mask_wr = reg_wr & hit_dmask;
  assign d_if.wdata   = reg_wdata;

  assign l_if.set     = lstat_set;
  assign l_if.rd_clr  = reg_rd & hit_lstat;
  assign l_if.mask_wr = reg_wr & hit_lmask;
  assign l_if.wdata   = reg_wdata[PORTS-1:0];

  sia_status_reg #(.W(`SIA_REG_W), .USED(`SIA_MSTAT_USED)) u_mstat (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .rif      (m_if.regs)
  );

  sia_status_reg #(.W(`SIA_REG_W), .USED(`SIA_DSTAT_USED)) u_dstat (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .rif      (d_if.regs)
  );

  sia_status_reg #(.W(PORTS), .USED(16'hffff)) u_lstat (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .rif      (l_if.regs)
  );

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  logic [`SIA_REG_W-1:0] lstat_word;
  logic [`SIA_REG_W-1:0] lmask_word;
  logic [`SIA_REG_W-1:0] rdata_sel;

  assign lstat_word = `SIA_REG_W'(l_if.status);
  assign lmask_word = `SIA_REG_W'(l_if.mask);
  // unmapped offsets read as zero
  // latched only on a read, so the word stands until the next read
  assign rdata_sel = hit_mstat ? m_if.status :
                     hit_mmask ? m_if.mask   :
                     hit_dstat ? d_if.status :
                     hit_dmask ? d_if.mask   :
                     hit_lstat ? lstat_word  :
                     hit_lmask ? lmask_word  : `SIA_RST_VAL;

  // ----------------------------------------------------------------------
  // interrupt pins
  // ----------------------------------------------------------------------
  // the local irq bit never reaches the local pin, it came from there
  wire mstat_local = |(m_if.status & m_if.mask
                       & ~(`SIA_REG_W'(1) << `SIA_BIT_LB_IRQ));
  wire any_host    = m_if.pending | d_if.pending | l_if.pending;
  wire any_local   = mstat_local | d_if.pending | l_if.pending;

  // registered so the pins cannot glitch while status words settle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata             <= `SIA_RST_VAL;
      host_irq_n            <= 1'b1;
      local_irq_n_out       <= 1'b1;
      local_irq_n_oe        <= 1'b0;
    end else begin
      if (reg_rd) begin
        reg_rdata <= rdata_sel;
      end
      host_irq_n            <= ~any_host;
      local_irq_n_out       <= ~(any_local & local_cfg_mode);
      local_irq_n_oe        <= local_cfg_mode;
    end
  end

  // ----------------------------------------------------------------------
  // host bus error copies
  // ----------------------------------------------------------------------
  // one-cycle copies for the configuration status kept outside this block;
  // the sticky versions live in the master status word
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_system_error_flag <= 1'b0;
      bus_parity_error_flag <= 1'b0;
    end else begin
      bus_system_error_flag <= bus_system_error;
      bus_parity_error_flag <= bus_parity_error;
    end
  end

endmodule

// ===== sim/sia_top_properties.sv
/*
  Port-level assertions for the status and interrupt aggregator top.
  Assumes a bind onto sia_top that hands on the same PORTS value.
*/
`timescale 1ns/10ps

module sia_top_properties #(
  parameter int PORTS = 16
) (
  input wire logic             core_clk,
  input wire logic             arst_n,
  input wire logic [7:0]       reg_addr,
  input wire logic             reg_rd,
  input wire logic [15:0]      reg_rdata,
  input wire logic [PORTS-1:0] port_rx_align_change,
  input wire logic [PORTS-1:0] rx_align_irq_enable,
  input wire logic             tester_bit_error,
  input wire logic             tester_bit_error_ie,
  input wire logic             bus_system_error,
  input wire logic             bus_parity_error,
  input wire logic             bus_system_error_flag,
  input wire logic             bus_parity_error_flag,
  input wire logic             local_cfg_mode,
  input wire logic             local_irq_n_out,
  input wire logic             local_irq_n_oe,
  input wire logic [PORTS-1:0] loopback_search_timeout,
  input wire logic [15:0]      dma_event
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  wire logic rd_mst = reg_rd && reg_addr == 8'h20;
  wire logic rd_dma = reg_rd && reg_addr == 8'h28;
  wire logic rd_lbk = reg_rd && reg_addr == 8'h30;

  a_sys_flag: assert property (bus_system_error |=> bus_system_error_flag)
    else $error("system error flag missing");
  a_par_cause: assert property (bus_parity_error_flag |-> $past(bus_parity_error))
    else $error("parity flag without cause");
  a_oe_mode: assert property ($changed(local_cfg_mode) |=>
    local_irq_n_oe == $past(local_cfg_mode)) else $error("local irq enable lags mode");
  a_bridge_quiet: assert property (!local_cfg_mode [*2] |-> local_irq_n_out)
    else $error("local irq driven in bridge mode");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h40
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_master_unused: assert property (rd_mst |=> (reg_rdata & 16'h3fe0) == 16'h0000)
    else $error("unused master bit set");
  a_dma_low: assert property (rd_dma |=> reg_rdata[1:0] == 2'b00)
    else $error("unused dma bits set");
  a_dma_ovfl: assert property (dma_event[5] ##1 rd_dma |=> reg_rdata[5])
    else $error("overflow event lost");
  a_tester_set: assert property (tester_bit_error && tester_bit_error_ie ##1 rd_mst
    |=> reg_rdata[2]) else $error("tester event lost");
  a_rx_gate: assert property (|(port_rx_align_change & rx_align_irq_enable) ##1 rd_mst
    |=> reg_rdata[0]) else $error("rx alignment event lost");
  a_lbk_hold: assert property (loopback_search_timeout[0] ##1 rd_lbk |=> reg_rdata[0])
    else $error("loopback timeout not held");
  a_par_record: assert property (bus_parity_error ##1 rd_mst |=> reg_rdata[4])
    else $error("parity event lost");
endmodule

// ===== sim/sia_host_model.sv
/*
  Host processor model: one register read or write per go pulse.
  Assumes go is a one-cycle pulse and the next go waits for done.
*/
`timescale 1ns/10ps

module sia_host_model (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        cfg,
  output logic             done,
  output logic [15:0]      rdata,
  output logic             reg_rd,
  output logic             reg_wr,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  logic [1:0] st_q;
  logic [7:0] a_q;
  // local bus bits carry no meaning in configuration mode
  wire logic [15:0] keep = (cfg && a_q == 8'h20) ? 16'h3fff : 16'hffff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q      <= 2'h0;
      a_q       <= 8'h00;
      done      <= 1'b0;
      rdata     <= 16'h0000;
      reg_rd    <= 1'b0;
      reg_wr    <= 1'b0;
      reg_addr  <= 8'h00;
      reg_wdata <= 16'h0000;
    end else begin
      reg_rd <= go && !wr;
      reg_wr <= go && wr;
      done   <= st_q == 2'h2;
      st_q   <= go ? 2'h1 : {st_q == 2'h1, 1'b0};
      if (go) begin
        a_q       <= addr;
        reg_addr  <= addr;
        reg_wdata <= wdata;
      end else begin
        // released lines toggle so a stale value can never pass
        reg_addr  <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
      end
      if (st_q == 2'h2) begin
        rdata <= reg_rdata & keep;
      end
    end
  end
endmodule

// ===== sim/tb_status_interrupt_aggregator.sv
/*
  Self-checking bench for the status and interrupt aggregator.
  Assumes sia_top, sia_host_model and sia_top_properties are compiled first.
*/
`timescale 1ns/10ps

module tb_status_interrupt_aggregator;
  logic        core_clk, arst_n, reg_rd, reg_wr, go, wr, done, host_irq_n;
  logic [7:0]  reg_addr, addr;
  logic [15:0] reg_wdata, reg_rdata, wdata, rdata, dma_event;
  logic [15:0] port_rx_align_change, rx_align_irq_enable, port_loopback_event;
  logic [15:0] port_tx_align_change, tx_align_irq_enable, loopback_search_timeout;
  logic        tester_sync_change, tester_bit_error, tester_count_overflow;
  logic        tester_sync_ie, tester_bit_error_ie, tester_overflow_ie;
  logic        bus_system_error, bus_parity_error, bus_system_error_flag;
  logic        bus_parity_error_flag, local_cfg_mode, local_access_start;
  logic        local_ready_n, local_irq_n_in, local_irq_n_out, local_irq_n_oe;
  int          fails, checks_done;

  sia_top #(.PORTS(16)) uut (.core_clk, .arst_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata, .port_rx_align_change, .rx_align_irq_enable, .port_tx_align_change,
    .tx_align_irq_enable, .tester_sync_change, .tester_bit_error, .tester_count_overflow,
    .tester_sync_ie, .tester_bit_error_ie, .tester_overflow_ie, .bus_system_error,
    .bus_parity_error, .bus_system_error_flag, .bus_parity_error_flag, .local_cfg_mode,
    .local_access_start, .local_ready_n, .local_irq_n_in, .local_irq_n_out,
    .local_irq_n_oe, .port_loopback_event, .loopback_search_timeout, .dma_event,
    .host_irq_n);

  sia_host_model host (.core_clk, .arst_n, .go, .wr, .addr, .wdata, .cfg(local_cfg_mode),
    .done, .rdata, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // event inputs are pulses: cleared one edge after they are raised
  task automatic quiet();
    port_rx_align_change <= 16'h0000;
    port_tx_align_change <= 16'h0000;
    {tester_sync_change, tester_bit_error, tester_count_overflow} <= 3'b000;
    {bus_system_error, bus_parity_error, local_access_start} <= 3'b000;
    port_loopback_event <= 16'h0000;
    dma_event <= 16'h0000;
  endtask

  // called on a rising edge; events raised at that edge land before the read
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    go <= 1'b0;
    quiet();
    repeat (8) if (done !== 1'b1) @(negedge core_clk);
    if (done !== 1'b1) fails++;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    chk(rdata, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic s_regs();
    for (int i = 0; i < 6; i++) rd(8'h20 + 8'(4 * i), 16'h0000);
    chk(16'(host_irq_n), 16'h0001);
    acc(1'b1, 8'h24, 16'hc01f);
    acc(1'b1, 8'h20, 16'hffff);
    acc(1'b1, 8'h40, 16'hffff);
    rd(8'h24, 16'hc01f);
    rd(8'h20, 16'h0000);
    rd(8'h40, 16'h0000);
    acc(1'b1, 8'h24, 16'h0000);
  endtask

  task automatic s_events();
    rx_align_irq_enable <= 16'h0008;
    tx_align_irq_enable <= 16'h8000;
    port_rx_align_change <= 16'h0004;
    port_tx_align_change <= 16'h7fff;
    rd(8'h20, 16'h0000);
    port_rx_align_change <= 16'h0008;
    port_tx_align_change <= 16'h8000;
    rd(8'h20, 16'h0003);
    rd(8'h20, 16'h0000);
    {tester_sync_change, tester_bit_error, tester_count_overflow} <= 3'b111;
    rd(8'h20, 16'h0000);
    {tester_sync_ie, tester_bit_error_ie, tester_overflow_ie} <= 3'b111;
    for (int i = 0; i < 3; i++) begin
      {tester_sync_change, tester_bit_error, tester_count_overflow} <= 3'(1 << i);
      rd(8'h20, 16'h0004);
    end
    bus_system_error <= 1'b1;
    rd(8'h20, 16'h0008);
    bus_parity_error <= 1'b1;
    rd(8'h20, 16'h0010);
  endtask

  task automatic s_irq();
    local_cfg_mode <= 1'b1;
    dma_event <= 16'h0020;
    acc(1'b1, 8'h2c, 16'h0000);
    settle();
    chk(16'(host_irq_n), 16'h0001);
    acc(1'b1, 8'h2c, 16'h0024);
    settle();
    chk(16'({host_irq_n, local_irq_n_out}), 16'h0000);
    dma_event <= 16'h0024;
    rd(8'h28, 16'h0024);
    settle();
    chk(16'({host_irq_n, local_irq_n_out}), 16'h0003);
    local_cfg_mode <= 1'b0;
  endtask

  task automatic s_local();
    acc(1'b1, 8'h24, 16'hc000);
    local_access_start <= 1'b1;
    @(posedge core_clk);
    quiet();
    repeat (15) @(posedge core_clk);
    rd(8'h20, 16'h4000);
    local_access_start <= 1'b1;
    @(posedge core_clk);
    quiet();
    repeat (4) @(posedge core_clk);
    local_ready_n <= 1'b0;
    repeat (15) @(posedge core_clk);
    local_ready_n <= 1'b1;
    rd(8'h20, 16'h0000);
    local_irq_n_in <= 1'b0;
    repeat (8) @(posedge core_clk);
    local_cfg_mode <= 1'b1;
    settle();
    chk(16'({host_irq_n, local_irq_n_out}), 16'h0001);
    local_cfg_mode <= 1'b0;
    local_irq_n_in <= 1'b1;
    rd(8'h20, 16'h8000);
    acc(1'b1, 8'h24, 16'h0000);
  endtask

  task automatic s_loop();
    port_loopback_event <= 16'h0080;
    rd(8'h30, 16'h0080);
    loopback_search_timeout <= 16'h0001;
    rd(8'h30, 16'h0001);
    rd(8'h30, 16'h0001);
    acc(1'b1, 8'h34, 16'h0001);
    settle();
    chk(16'(host_irq_n), 16'h0000);
    loopback_search_timeout <= 16'h0000;
    rd(8'h30, 16'h0001);
    rd(8'h30, 16'h0000);
    settle();
    chk(16'(host_irq_n), 16'h0001);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    close_out();
  end

  initial begin
    arst_n = 1'b0;
    {go, wr, addr, wdata} = 26'h0;
    {rx_align_irq_enable, tx_align_irq_enable, loopback_search_timeout} = 48'h0;
    {tester_sync_ie, tester_bit_error_ie, tester_overflow_ie, local_cfg_mode} = 4'h0;
    {local_ready_n, local_irq_n_in} = 2'b11;
    quiet();
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    s_regs();
    s_events();
    s_irq();
    s_local();
    s_loop();
    close_out();
  end
endmodule

bind sia_top sia_top_properties #(.PORTS(PORTS)) u_props (.core_clk, .arst_n, .reg_addr,
  .reg_rd, .reg_rdata, .port_rx_align_change, .rx_align_irq_enable, .tester_bit_error,
  .tester_bit_error_ie, .bus_system_error, .bus_parity_error, .bus_system_error_flag,
  .bus_parity_error_flag, .local_cfg_mode, .local_irq_n_out, .local_irq_n_oe,
  .loopback_search_timeout, .dma_event);
